// file: sim/ethcg_gate_sva.sv
/* Port checker for the command gate and loss watchdog.
   Bound onto ethcg_gate; everything lives in the ref_clk domain. */
`default_nettype none
module ethcg_gate_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic frame_valid,
    input wire logic frame_has_cmd,
    input wire logic conn_req,
    input wire logic net_mode,
    input wire logic cmd_src_eth,
    input wire logic light_proto_en,
    input wire logic timed_proto_en,
    input wire logic [1:0] remote_layout,
    input wire logic remote_plc_mode,
    input wire logic [2:0] link_speed_duplex,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic conn_accept,
    input wire logic conn_reject,
    input wire logic ethernet_comm_fault,
    input wire logic output_shutoff
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic ctl_wr;
    // Control word write, used for apply and fault clear
    assign ctl_wr = reg_wr && reg_addr == 8'h50;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_shutoff_fault: assert property (output_shutoff == ethernet_comm_fault)
        else $error("shutoff differs from fault");
    a_cmd_answer: assert property (frame_valid && frame_has_cmd |=> cmd_accept != cmd_reject)
        else $error("command frame without single answer");
    a_cmd_cause: assert property (cmd_accept || cmd_reject |-> $past(frame_valid && frame_has_cmd))
        else $error("command answer without frame");
    a_conn_answer: assert property (conn_req |=> conn_accept != conn_reject)
        else $error("connection without single answer");
    a_conn_cause: assert property (conn_accept || conn_reject |-> $past(conn_req))
        else $error("connection answer without request");
    a_proto_excl: assert property (!(light_proto_en && timed_proto_en))
        else $error("both protocols enabled");
    a_link_legal: assert property (link_speed_duplex <= 3'h4)
        else $error("link speed out of range");
    a_apply_only: assert property ($changed({remote_plc_mode, remote_layout, link_speed_duplex})
        |-> $past(ctl_wr && reg_wr_data[0]) || $past(ctl_wr && reg_wr_data[0], 2)
        || $past(ctl_wr && reg_wr_data[0], 3))
        else $error("active setting changed without apply");
    a_fault_clear: assert property ($fell(ethernet_comm_fault)
        |-> $past(ctl_wr && reg_wr_data[1]) || $past(ctl_wr && reg_wr_data[1], 2))
        else $error("fault dropped without clear");
    a_fault_net: assert property ($rose(ethernet_comm_fault) |-> $past(net_mode && cmd_src_eth))
        else $error("fault raised outside network mode");
    // Main scenarios reached
    c_accept: cover property (cmd_accept);
    c_reject: cover property (cmd_reject);
    c_conn_ref: cover property (conn_reject);
    c_fault: cover property ($rose(ethernet_comm_fault));
endmodule
bind ethcg_gate ethcg_gate_sva i_ethcg_gate_sva (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
    .frame_valid(frame_valid), .frame_has_cmd(frame_has_cmd), .conn_req(conn_req),
    .net_mode(net_mode), .cmd_src_eth(cmd_src_eth), .light_proto_en(light_proto_en),
    .timed_proto_en(timed_proto_en), .remote_layout(remote_layout),
    .remote_plc_mode(remote_plc_mode), .link_speed_duplex(link_speed_duplex),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .conn_accept(conn_accept),
    .conn_reject(conn_reject), .ethernet_comm_fault(ethernet_comm_fault),
    .output_shutoff(output_shutoff));
`default_nettype wire

// file: sim/ethcg_gate_tb.sv
/* Self-checking bench for ethcg_gate with a short 10-cycle check tick.
   Assumes the master model file and the bound checker are compiled. */
`default_nettype none
`define chk(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module ethcg_gate_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, conn_req = 1'b0;
    logic net_mode = 1'b0, cmd_src_eth = 1'b1, f_en = 1'b0, f_cmd = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wr_data = 16'h0000, d;
    logic [31:0] conn_src_ip = 32'h00000000, f_ip = 32'h00000000;
    wire [15:0] reg_rd_data;
    wire [31:0] frame_src_ip;
    wire [2:0] link_speed_duplex;
    wire [1:0] remote_layout;
    wire frame_valid, frame_has_cmd, light_proto_en, timed_proto_en, remote_plc_mode;
    wire cmd_accept, cmd_reject, conn_accept, conn_reject, ethernet_comm_fault;
    wire output_shutoff, irq;
    int error_cnt = 0, n_compared = 0, i;
    logic [15:0] rst_fs [4] = '{16'h1389, 16'hB0B5, 16'hB0B6, 16'h270F};
    logic [7:0] cfg_a [14] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h2C,
        8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h08};
    logic [15:0] cfg_d [14] = '{16'h00C0, 16'h00A8, 16'h0032, 16'h006E, 16'h270F,
        16'h0064, 16'h00C0, 16'h00A8, 16'h0001, 16'h0064, 16'h270F, 16'h0003,
        16'h0096, 16'hF00A};
    logic [31:0] ips [6] = '{32'hC0A83264, 32'hC0A83269, 32'hC0A8326E, 32'hC0A8326F,
        32'hC0A83369, 32'hC0A83263};
    logic [31:0] cips [6] = '{32'hC0A80278, 32'hC0A80178, 32'hC0A80296, 32'hC0A80297,
        32'hC0A80478, 32'hC0A90278};
    logic [15:0] ext_v [8] = '{16'h0000, 16'h0001, 16'h000C, 16'h000E, 16'h0012,
        16'h0026, 16'h0070, 16'h008A};
    logic [2:0] ext_e [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h5, 3'h7};
    // Clock of 25 ns
    always #12.5 ref_clk = ~ref_clk;
    ethcg_gate #(.TICK_CYCLES(32'd10)) i_ethcg_gate (.ref_clk(ref_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .frame_valid(frame_valid), .frame_src_ip(frame_src_ip),
        .frame_has_cmd(frame_has_cmd), .conn_req(conn_req), .conn_src_ip(conn_src_ip),
        .net_mode(net_mode), .cmd_src_eth(cmd_src_eth), .light_proto_en(light_proto_en),
        .timed_proto_en(timed_proto_en), .remote_layout(remote_layout),
        .remote_plc_mode(remote_plc_mode), .link_speed_duplex(link_speed_duplex),
        .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .conn_accept(conn_accept),
        .conn_reject(conn_reject), .ethernet_comm_fault(ethernet_comm_fault),
        .output_shutoff(output_shutoff), .irq(irq));
    ethcg_master_model i_ethcg_master_model (.ref_clk(ref_clk), .en(f_en), .gap(8'd19),
        .ip(f_ip), .has_cmd(f_cmd), .frame_valid(frame_valid),
        .frame_src_ip(frame_src_ip), .frame_has_cmd(frame_has_cmd));
    // Register port cycles, one-cycle strobes
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rd_data;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Drive reset stands in for a power cycle of the settings
    task apply;
        wr(8'h50, 16'h0001);
        tick(3);
    endtask
    // One frame from the master, answer sampled a cycle on
    task frame(input logic [31:0] a);
        @(posedge ref_clk) f_ip <= a;
        f_en <= 1'b1;
        @(posedge ref_clk) f_en <= 1'b0;
        tick(1);
    endtask
    task conn(input logic [31:0] a);
        @(posedge ref_clk) conn_req <= 1'b1;
        conn_src_ip <= a;
        @(posedge ref_clk) conn_req <= 1'b0;
        conn_src_ip <= ~a;
        #1;
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard, far above the roughly 800 cycles of the tests
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim();
    end
    // Test sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rd(8'(i * 4), d);
            `chk("func_sel", rst_fs[i], d)
        end
        rd(8'h28, d);
        `chk("interval", 16'h000F, d)
        `chk("timed_proto_en", 1'b1, timed_proto_en)
        `chk("light_proto_en", 1'b0, light_proto_en)
        conn(32'h0A000001);
        `chk("conn_accept", 1'b1, conn_accept)
        frame(32'hC0A83269);
        `chk("cmd_reject", 1'b1, cmd_reject)
        wr(8'h5C, 16'h0007);
        tick(2);
        `chk("irq", 1'b1, irq)
        rd(8'h58, d);
        `chk("irq_status", 16'h0002, d)
        tick(2);
        `chk("irq", 1'b0, irq)
        $display("done: reset and empty source");
        for (i = 0; i < 14; i++) wr(cfg_a[i], cfg_d[i]);
        frame(32'hC0A83269);
        `chk("cmd_reject", 1'b1, cmd_reject)
        `chk("timed_proto_en", 1'b1, timed_proto_en)
        apply();
        `chk("light_proto_en", 1'b1, light_proto_en)
        `chk("timed_proto_en", 1'b0, timed_proto_en)
        for (i = 0; i < 6; i++) begin
            frame(ips[i]);
            `chk("cmd_accept", i < 3, cmd_accept)
        end
        for (i = 0; i < 6; i++) begin
            conn(cips[i]);
            `chk("conn_accept", i < 3, conn_accept)
            `chk("conn_reject", i >= 3, conn_reject)
        end
        rd(8'h58, d);
        `chk("irq_status", 16'h0006, d)
        wr(8'h2C, 16'h0100);
        rd(8'h2C, d);
        `chk("filter_octet", 16'h00C0, d)
        wr(8'h0C, 16'hB0B6);
        apply();
        `chk("timed_proto_en", 1'b1, timed_proto_en)
        `chk("light_proto_en", 1'b0, light_proto_en)
        $display("done: filters and protocols");
        for (i = 0; i < 8; i++) begin
            wr(8'h48, ext_v[i]);
            apply();
            `chk("layout", ext_e[i], {remote_plc_mode, remote_layout})
        end
        wr(8'h4C, 16'h0004);
        apply();
        `chk("link", 3'h4, link_speed_duplex)
        wr(8'h4C, 16'h0005);
        rd(8'h4C, d);
        `chk("link_setting", 16'h0004, d)
        $display("done: layouts and link");
        wr(8'h28, 16'h0003);
        @(posedge ref_clk) net_mode <= 1'b1;
        tick(100);
        `chk("fault", 1'b0, ethernet_comm_fault)
        @(posedge ref_clk) f_cmd <= 1'b0;
        f_ip <= 32'hC0A83264;
        f_en <= 1'b1;
        tick(200);
        `chk("fault", 1'b0, ethernet_comm_fault)
        @(posedge ref_clk) f_en <= 1'b0;
        tick(20);
        `chk("fault", 1'b0, ethernet_comm_fault)
        for (i = 0; i < 40 && ethernet_comm_fault !== 1'b1; i++) tick(1);
        `chk("fault", 1'b1, ethernet_comm_fault)
        `chk("shutoff", 1'b1, output_shutoff)
        // Interrupt line trails the status bit by one cycle
        tick(1);
        `chk("irq", 1'b1, irq)
        rd(8'h58, d);
        `chk("irq_status", 16'h0001, d)
        @(posedge ref_clk) net_mode <= 1'b0;
        wr(8'h50, 16'h0002);
        tick(2);
        `chk("fault", 1'b0, ethernet_comm_fault)
        wr(8'h28, 16'h270F);
        @(posedge ref_clk) net_mode <= 1'b1;
        f_en <= 1'b1;
        tick(40);
        @(posedge ref_clk) f_en <= 1'b0;
        tick(200);
        `chk("fault", 1'b0, ethernet_comm_fault)
        rd(8'h54, d);
        `chk("state", 16'h000C, d)
        @(posedge ref_clk) cmd_src_eth <= 1'b0;
        wr(8'h28, 16'h0000);
        tick(3);
        `chk("fault", 1'b0, ethernet_comm_fault)
        @(posedge ref_clk) cmd_src_eth <= 1'b1;
        tick(3);
        `chk("fault", 1'b1, ethernet_comm_fault)
        $display("done: watchdog");
        @(posedge ref_clk) reset <= 1'b1;
        tick(3);
        @(posedge ref_clk) reset <= 1'b0;
        tick(1);
        `chk("fault", 1'b0, ethernet_comm_fault)
        rd(8'h28, d);
        `chk("interval", 16'h000F, d)
        $display("done: second reset");
        end_sim();
    end
endmodule
`default_nettype wire

// file: sim/ethcg_master_model.sv
/* Network master model: sends cyclic frames from one address.
   Assumes the bench sets en, gap, ip and has_cmd on ref_clk edges. */
`default_nettype none
module ethcg_master_model (
    input wire logic ref_clk,
    input wire logic en,
    input wire logic [7:0] gap,
    input wire logic [31:0] ip,
    input wire logic has_cmd,
    output logic frame_valid,
    output logic [31:0] frame_src_ip,
    output logic frame_has_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;
    // Idle lines start defined, then churn so stale values never match
    initial begin
        frame_valid = 1'b0;
        frame_src_ip = 32'h00000000;
        frame_has_cmd = 1'b0;
        cnt_reg = 8'h00;
    end
    // frame every gap plus one cycles while enabled
    always @(posedge ref_clk) begin
        frame_valid <= 1'b0;
        frame_src_ip <= ~frame_src_ip;
        frame_has_cmd <= ~frame_has_cmd;
        if (!en) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == 8'h00) begin
            frame_valid <= 1'b1;
            frame_src_ip <= ip;
            frame_has_cmd <= has_cmd;
            cnt_reg <= gap;
        end else begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: src/ethcg_defines.vh
/*
 * Constants for the Ethernet command gate and watchdog: register byte
 * offsets, setting indices, reset values, field positions, timing counts.
 * Assumes it is included by bare name from the design files under src/.
 */
// What this block does
// - Value 61450 in any selector enables light protocol
// - Value 45238 anywhere gives timed protocol priority
// - All command octets zero rejects every command
// - Octets 3 and 4 match either-ordered ranges
// - Bound 9999 means single octet value only
// - Silence from permitted senders raises fault, shutoff
// - Check interval 9999 disables loss detection
// - Interval zero faults at once in network mode
// - Every frame from a permitted sender clears check counter
// - Check starts at first frame in network mode
// - Connection filter octets, bounds; all zero disables
// - Extension setting selects remote register layout
// - Setting 0 to 4 picks speed and duplex
// - Marked settings apply only after drive reset
// - Interval 0.1 to 999.8 s, shutoff past it
`ifndef ETHCG_DEFINES_VH
`define ETHCG_DEFINES_VH

// Setting indices, byte offset is index times four
`define ETHCG_IDX_FUNC_SEL_1 5'd0
`define ETHCG_IDX_CMD_OCT_1 5'd4
`define ETHCG_IDX_CMD_OCT_3_BOUND 5'd8
`define ETHCG_IDX_CMD_OCT_4_BOUND 5'd9
`define ETHCG_IDX_CHECK_INTERVAL 5'd10
`define ETHCG_IDX_FILT_OCT_1 5'd11
`define ETHCG_IDX_FILT_OCT_2_BOUND 5'd15
`define ETHCG_IDX_FILT_OCT_4_BOUND 5'd17
`define ETHCG_IDX_REMOTE_EXT 5'd18
`define ETHCG_IDX_LINK_SPEED 5'd19
`define ETHCG_NUM_SETTINGS 20

// Byte offsets of the control and status words
`define ETHCG_OFF_CTRL 8'h50
`define ETHCG_OFF_STATE 8'h54
`define ETHCG_OFF_IRQ_STATUS 8'h58
`define ETHCG_OFF_IRQ_MASK 8'h5C

// Control word bits
`define ETHCG_CTRL_APPLY 0
`define ETHCG_CTRL_FAULT_CLR 1

// Interrupt status bits
`define ETHCG_IRQ_FAULT 0
`define ETHCG_IRQ_CMD_REJECT 1
`define ETHCG_IRQ_CONN_REJECT 2
`define ETHCG_IRQ_BITS 3

// Setting values with a meaning of their own
`define ETHCG_PROTO_LIGHT 16'hF00A
`define ETHCG_PROTO_TIMED 16'hB0B6
`define ETHCG_UNUSED 16'h270F
`define ETHCG_OCTET_MAX 16'h00FF
`define ETHCG_LINK_SPEED_MAX 16'h0004

// Reset values
`define ETHCG_RST_FUNC_SEL_1 16'h1389
`define ETHCG_RST_FUNC_SEL_2 16'hB0B5
`define ETHCG_RST_FUNC_SEL_3 16'hB0B6
`define ETHCG_RST_FUNC_SEL_4 16'h270F
`define ETHCG_RST_CHECK_INTERVAL 16'h000F

// Remote register layouts
`define ETHCG_LAYOUT_SINGLE 2'h0
`define ETHCG_LAYOUT_DOUBLE 2'h1
`define ETHCG_LAYOUT_QUAD 2'h2
`define ETHCG_LAYOUT_OCTUPLE 2'h3
`define ETHCG_EXT_PLC_BASE 16'h0064

// Timing: check tick of 0.1 s at a 25 ns clock
`define ETHCG_TICK_NS 100000000
`define ETHCG_CLK_PERIOD_NS 25
`define ETHCG_TICK_CYCLES (`ETHCG_TICK_NS / `ETHCG_CLK_PERIOD_NS)

`endif

// file: src/ethcg_gate.v
/*
 * Ethernet command gate and communication-loss watchdog: settings store
 * with drive-reset apply, protocol selection, command source and
 * connection filtering, loss timer with fault and output shutoff.
 * Assumes frame strobes come from receive logic on ref_clk, and that the
 * register port master follows one-cycle strobes with read data a cycle on.
 */
`default_nettype none
`include "ethcg_defines.vh"

module ethcg_gate #(
    parameter [31:0] TICK_CYCLES = `ETHCG_TICK_CYCLES
) (
    input wire ref_clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wr_data,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rd_data,
    input wire frame_valid,
    input wire [31:0] frame_src_ip,
    input wire frame_has_cmd,
    input wire conn_req,
    input wire [31:0] conn_src_ip,
    input wire net_mode,
    input wire cmd_src_eth,
    output reg light_proto_en,
    output reg timed_proto_en,
    output reg [1:0] remote_layout,
    output reg remote_plc_mode,
    output reg [2:0] link_speed_duplex,
    output reg cmd_accept,
    output reg cmd_reject,
    output reg conn_accept,
    output reg conn_reject,
    output reg ethernet_comm_fault,
    output reg output_shutoff,
    output reg irq
);

    integer i;

    // Pending settings as written, active copies as applied
    reg [15:0] pend_reg [0:`ETHCG_NUM_SETTINGS-1];
    reg [15:0] act_reg [0:`ETHCG_NUM_SETTINGS-1];
    reg [`ETHCG_IRQ_BITS-1:0] irq_status_reg;
    reg [`ETHCG_IRQ_BITS-1:0] irq_mask_reg;
    reg [21:0] tick_reg;
    reg [15:0] elapsed_reg;
    reg armed_reg;

    wire [4:0] idx = reg_addr[6:2];
    wire idx_ok = (reg_addr[7] == 1'b0) && (reg_addr[1:0] == 2'b00)
        && (idx < `ETHCG_NUM_SETTINGS);
    wire wr_ctrl = reg_wr && (reg_addr == `ETHCG_OFF_CTRL);
    wire apply = wr_ctrl && reg_wr_data[`ETHCG_CTRL_APPLY];
    wire fault_clr = wr_ctrl && reg_wr_data[`ETHCG_CTRL_FAULT_CLR];
    wire [15:0] interval = act_reg[`ETHCG_IDX_CHECK_INTERVAL];

    // Power-on value of each setting
    function [15:0] init_val;
        input [4:0] n;
        begin
            case (n)
                5'd0: init_val = `ETHCG_RST_FUNC_SEL_1;
                5'd1: init_val = `ETHCG_RST_FUNC_SEL_2;
                5'd2: init_val = `ETHCG_RST_FUNC_SEL_3;
                5'd3: init_val = `ETHCG_RST_FUNC_SEL_4;
                5'd8, 5'd9, 5'd15, 5'd16, 5'd17: init_val = `ETHCG_UNUSED;
                5'd10: init_val = `ETHCG_RST_CHECK_INTERVAL;
                default: init_val = 16'h0000;
            endcase
        end
    endfunction

    // Out-of-range writes are dropped so the active set stays legal
    function wr_ok;
        input [4:0] n;
        input [15:0] v;
        begin
            if (n < `ETHCG_IDX_CMD_OCT_1) begin
                wr_ok = 1'b1;
            end else if (n == `ETHCG_IDX_CMD_OCT_3_BOUND || n == `ETHCG_IDX_CMD_OCT_4_BOUND
                || (n >= `ETHCG_IDX_FILT_OCT_2_BOUND && n <= `ETHCG_IDX_FILT_OCT_4_BOUND)) begin
                wr_ok = (v <= `ETHCG_OCTET_MAX) || (v == `ETHCG_UNUSED);
            end else if (n == `ETHCG_IDX_CHECK_INTERVAL) begin
                wr_ok = (v <= `ETHCG_UNUSED);
            end else if (n == `ETHCG_IDX_REMOTE_EXT) begin
                wr_ok = 1'b1;
            end else if (n == `ETHCG_IDX_LINK_SPEED) begin
                wr_ok = (v <= `ETHCG_LINK_SPEED_MAX);
            end else begin
                wr_ok = (v <= `ETHCG_OCTET_MAX);
            end
        end
    endfunction

    // Protocol selectors: any of four holds the value
    function any_sel;
        input [15:0] a;
        input [15:0] b;
        input [15:0] c;
        input [15:0] d;
        input [15:0] v;
        begin
            any_sel = (a == v) || (b == v) || (c == v) || (d == v);
        end
    endfunction

    // Settings store; only the interval takes effect at once
    // apply on reset
    always @(posedge ref_clk) begin
        if (reset) begin
            for (i = 0; i < `ETHCG_NUM_SETTINGS; i = i + 1) begin
                pend_reg[i] <= init_val(i[4:0]);
                act_reg[i] <= init_val(i[4:0]);
            end
        end else begin
            if (reg_wr && idx_ok && wr_ok(idx, reg_wr_data)) begin
                pend_reg[idx] <= reg_wr_data;
            end
            for (i = 0; i < `ETHCG_NUM_SETTINGS; i = i + 1) begin
                if (apply) begin
                    act_reg[i] <= pend_reg[i];
                end
            end
            act_reg[`ETHCG_IDX_CHECK_INTERVAL] <= pend_reg[`ETHCG_IDX_CHECK_INTERVAL];
        end
    end

    wire [31:0] cmd_base = {act_reg[4][7:0], act_reg[5][7:0], act_reg[6][7:0],
        act_reg[7][7:0]};
    wire [31:0] filt_base = {act_reg[11][7:0], act_reg[12][7:0], act_reg[13][7:0],
        act_reg[14][7:0]};
    wire cmd_zero;
    wire cmd_hit;
    wire filt_zero;
    wire filt_hit;

    ethcg_ip_match u_cmd_match (
        .src_ip(frame_src_ip),
        .base_ip(cmd_base),
        .bound_2(`ETHCG_UNUSED),
        .bound_3(act_reg[`ETHCG_IDX_CMD_OCT_3_BOUND]),
        .bound_4(act_reg[`ETHCG_IDX_CMD_OCT_4_BOUND]),
        .all_zero(cmd_zero),
        .hit(cmd_hit)
    );

    ethcg_ip_match u_filt_match (
        .src_ip(conn_src_ip),
        .base_ip(filt_base),
        .bound_2(act_reg[15]),
        .bound_3(act_reg[16]),
        .bound_4(act_reg[17]),
        .all_zero(filt_zero),
        .hit(filt_hit)
    );

    wire cmd_ok = !cmd_zero && cmd_hit;
    wire from_source = frame_valid && cmd_ok;

    // Decoded configuration outputs
    always @(posedge ref_clk) begin
        if (reset) begin
            light_proto_en <= 1'b0;
            timed_proto_en <= 1'b0;
            remote_layout <= `ETHCG_LAYOUT_SINGLE;
            remote_plc_mode <= 1'b0;
            link_speed_duplex <= 3'h0;
        end else begin
            timed_proto_en <= any_sel(act_reg[0], act_reg[1], act_reg[2], act_reg[3],
                `ETHCG_PROTO_TIMED);
            light_proto_en <= any_sel(act_reg[0], act_reg[1], act_reg[2], act_reg[3],
                `ETHCG_PROTO_LIGHT) && !any_sel(act_reg[0], act_reg[1], act_reg[2],
                act_reg[3], `ETHCG_PROTO_TIMED);
            remote_plc_mode <= (act_reg[`ETHCG_IDX_REMOTE_EXT] >= `ETHCG_EXT_PLC_BASE);
            case (act_reg[`ETHCG_IDX_REMOTE_EXT])
                16'h000C, 16'h0070: remote_layout <= `ETHCG_LAYOUT_DOUBLE;
                16'h000E, 16'h0072: remote_layout <= `ETHCG_LAYOUT_QUAD;
                16'h0012, 16'h0026, 16'h0076, 16'h008A: remote_layout <= `ETHCG_LAYOUT_OCTUPLE;
                default: remote_layout <= `ETHCG_LAYOUT_SINGLE;
            endcase
            link_speed_duplex <= act_reg[`ETHCG_IDX_LINK_SPEED][2:0];
        end
    end

    // Per-frame accept and reject pulses
    always @(posedge ref_clk) begin
        if (reset) begin
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            conn_accept <= 1'b0;
            conn_reject <= 1'b0;
        end else begin
            cmd_accept <= frame_valid && frame_has_cmd && cmd_ok;
            cmd_reject <= frame_valid && frame_has_cmd && !cmd_ok;
            conn_accept <= conn_req && (filt_zero || filt_hit);
            conn_reject <= conn_req && !filt_zero && !filt_hit;
        end
    end

    // Watchdog runs only in network mode with Ethernet as source
    wire monitor = net_mode && cmd_src_eth && (interval != `ETHCG_UNUSED);
    wire tick = (tick_reg == TICK_CYCLES[21:0] - 22'h000001);
    wire expire = armed_reg && (interval != 16'h0000) && (elapsed_reg >= interval);
    wire instant = monitor && (interval == 16'h0000);
    wire fault_set = monitor && (expire || instant);

    always @(posedge ref_clk) begin
        if (reset) begin
            tick_reg <= 22'h000000;
            elapsed_reg <= 16'h0000;
            armed_reg <= 1'b0;
        end else if (!monitor) begin
            tick_reg <= 22'h000000;
            elapsed_reg <= 16'h0000;
            armed_reg <= 1'b0;
        end else if (from_source) begin
            tick_reg <= 22'h000000;
            elapsed_reg <= 16'h0000;
            armed_reg <= 1'b1;
        end else if (armed_reg) begin
            tick_reg <= tick ? 22'h000000 : tick_reg + 22'h000001;
            if (tick && elapsed_reg != 16'hFFFF) begin
                elapsed_reg <= elapsed_reg + 16'h0001;
            end
        end
    end

    // Fault holds until cleared; a new expiry beats the clear
    // fault and shutoff
    always @(posedge ref_clk) begin
        if (reset) begin
            ethernet_comm_fault <= 1'b0;
            output_shutoff <= 1'b0;
        end else if (fault_set) begin
            ethernet_comm_fault <= 1'b1;
            output_shutoff <= 1'b1;
        end else if (fault_clr) begin
            ethernet_comm_fault <= 1'b0;
            output_shutoff <= 1'b0;
        end
    end

    // Sticky events; a read clears, an event in that cycle survives
    wire [`ETHCG_IRQ_BITS-1:0] events = {conn_req && !filt_zero && !filt_hit,
        frame_valid && frame_has_cmd && !cmd_ok, fault_set && !ethernet_comm_fault};
    wire rd_status = reg_rd && (reg_addr == `ETHCG_OFF_IRQ_STATUS);

    always @(posedge ref_clk) begin
        if (reset) begin
            irq_status_reg <= {`ETHCG_IRQ_BITS{1'b0}};
            irq_mask_reg <= {`ETHCG_IRQ_BITS{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (rd_status ? {`ETHCG_IRQ_BITS{1'b0}} : irq_status_reg) | events;
            if (reg_wr && reg_addr == `ETHCG_OFF_IRQ_MASK) begin
                irq_mask_reg <= reg_wr_data[`ETHCG_IRQ_BITS-1:0];
            end
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Read data one cycle after the strobe; zero otherwise
    always @(posedge ref_clk) begin
        if (reset) begin
            reg_rd_data <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rd_data <= 16'h0000;
        end else if (idx_ok) begin
            reg_rd_data <= pend_reg[idx];
        end else begin
            case (reg_addr)
                `ETHCG_OFF_STATE: reg_rd_data <= {10'h000, armed_reg, ethernet_comm_fault,
                    remote_plc_mode, timed_proto_en, light_proto_en, monitor};
                `ETHCG_OFF_IRQ_STATUS: reg_rd_data <= {13'h0000, irq_status_reg};
                `ETHCG_OFF_IRQ_MASK: reg_rd_data <= {13'h0000, irq_mask_reg};
                default: reg_rd_data <= 16'h0000;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: src/ethcg_ip_match.v
/*
 * Address range matcher: compares a source address against four base
 * octets and optional range bounds on octets 2 to 4.
 * Assumes bounds hold 0 to 255 or the unused marker; purely combinational.
 */
`default_nettype none
`include "ethcg_defines.vh"

module ethcg_ip_match (
    input wire [31:0] src_ip,
    input wire [31:0] base_ip,
    input wire [15:0] bound_2,
    input wire [15:0] bound_3,
    input wire [15:0] bound_4,
    output wire all_zero,
    output wire hit
);

    // Either ordering of base and bound is allowed
    function in_range;
        input [7:0] octet;
        input [7:0] base;
        input [15:0] bound;
        begin
            if (bound == `ETHCG_UNUSED) begin
                in_range = (octet == base);
            end else if (bound[7:0] >= base) begin
                in_range = (octet >= base) && (octet <= bound[7:0]);
            end else begin
                in_range = (octet >= bound[7:0]) && (octet <= base);
            end
        end
    endfunction

    // Octet 1 always exact, lower octets by range
    assign all_zero = (base_ip == 32'h00000000);
    assign hit = (src_ip[31:24] == base_ip[31:24])
        && in_range(src_ip[23:16], base_ip[23:16], bound_2)
        && in_range(src_ip[15:8], base_ip[15:8], bound_3)
        && in_range(src_ip[7:0], base_ip[7:0], bound_4);

endmodule
`default_nettype wire
